/* common/phy_np_irq_consts.svh */
`ifndef PHY_NP_IRQ_CONSTS_SVH
`define PHY_NP_IRQ_CONSTS_SVH

// Register addresses
`define ADDR_LOCAL_NP 5'h07
`define ADDR_PARTNER_NP 5'h08
`define ADDR_RXERR_CNT 5'h15
`define ADDR_IRQ_CTRL 5'h1b
`define ADDR_PHY_CTRL 5'h1f

// Local next-page fields
`define NP_MORE_BIT 15
`define NP_ACK_BIT 14
`define NP_MSG_PAGE_BIT 13
`define NP_ACK2_BIT 12
`define NP_TOGGLE_BIT 11
`define NP_MSG_W 11
`define NP_MSG_RESET 11'h001

// Interrupt register layout
`define IRQ_EN_LSB 8
`define IRQ_FLAG_LINK_UP 0
`define IRQ_FLAG_REMOTE_FAULT 1
`define IRQ_FLAG_LINK_DOWN 2
`define IRQ_FLAG_PARTNER_ACK 3
`define IRQ_FLAG_PAR_DET_FAULT 4
`define IRQ_FLAG_PAGE_RX 5
`define IRQ_FLAG_RX_ERR 6
`define IRQ_FLAG_JABBER 7

// Control register fields
`define CTL_XOVER_DIS_BIT 13
`define CTL_ENERGY_BIT 12
`define CTL_FORCE_LINK_BIT 11
`define CTL_PWR_SAVE_BIT 10
`define CTL_IRQ_LEVEL_BIT 9
`define CTL_JABBER_EN_BIT 8
`define CTL_AN_DONE_BIT 7
`define CTL_PAUSE_BIT 6
`define CTL_ISOLATE_BIT 5
`define CTL_SQE_BIT 1
`define CTL_SCRAMBLE_DIS_BIT 0
`define CTL_PWR_SAVE_RESET 1'b1
`define CTL_JABBER_EN_RESET 1'b1

`endif

/* common/phy_np_irq_pkg.sv */
`default_nettype none
package phy_np_irq_pkg;
    typedef logic [15:0] reg_word_t;
    typedef logic [4:0] reg_addr_t;
endpackage : phy_np_irq_pkg
`default_nettype wire

/* rtl/phy_nextpage_irq_ctrl_regs.sv */
// Overview of operation
// RULE_01 - Local next-page bit 15 writable, more pages follow flag, resets 0
// RULE_02 - Local bit 13 writable message-page select, resets 1
// RULE_03 - Local bit 12 writable second-acknowledge, resets 0
// RULE_04 - Local bit 11 read-only, shows last transmitted toggle value, resets 0
// RULE_05 - Local bits 10..0 writable message code, resets to 001
// RULE_06 - Partner register read-only capture of partner page; bit 14 received ack
// RULE_07 - Partner bit 11 reads 1 when previous sent toggle was zero
// RULE_08 - Partner bit 12 shows partner second-acknowledge
// RULE_09 - Sixteen-bit read-only receive-error counter, resets zero
// RULE_10 - Interrupt bits 15..8 writable enables, reset 0
// RULE_11 - Interrupt bits 7..0 event flags, set on event, cleared by read
// RULE_12 - Link down sets flag 2, link up sets flag 0, separately
// RULE_13 - Control bit 13 disables auto crossover, resets 0
// RULE_14 - Control bit 12 reports receive energy present
// RULE_15 - Control bit 11 forces link pass
// RULE_16 - Control bit 10 enables power saving, resets 1
// RULE_17 - Control bit 9 selects interrupt pin polarity, resets 0
// RULE_18 - Control bit 8 enables jabber counter, resets 1
// RULE_19 - Control bit 7 shows negotiation complete
// RULE_20 - Control bit 6 reports flow-control result
// RULE_21 - Control bit 5 reports isolate mode
// RULE_22 - Control bit 1 SQE test, bit 0 scrambler bypass, both reset 0
// RULE_23 - Interrupt output active while any enabled flag set, at chosen polarity
`timescale 1ns/1ps
`include "phy_np_irq_consts.svh"
`default_nettype none

module phy_nextpage_irq_ctrl_regs #(
    parameter int EVENT_COUNT = 8
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // Management access, same clock domain
    input wire logic reg_rd_in,
    input wire logic reg_wr_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_hit_out,
    // Negotiation engine side
    input wire logic np_sent_in,
    input wire logic np_sent_toggle_in,
    input wire logic partner_np_valid_in,
    input wire logic [15:0] partner_np_in,
    input wire logic an_done_in,
    input wire logic pause_result_in,
    // Receive and link status
    input wire logic rx_err_in,
    input wire logic rx_pkt_active_in,
    input wire logic energy_in,
    input wire logic isolate_in,
    input wire logic link_up_in,
    input wire logic jabber_evt_in,
    input wire logic page_rx_evt_in,
    input wire logic par_det_fault_evt_in,
    input wire logic partner_ack_evt_in,
    input wire logic remote_fault_evt_in,
    // Controls toward the PHY
    output logic [15:0] local_np_out,
    output logic xover_dis_out,
    output logic force_link_out,
    output logic pwr_save_out,
    output logic jabber_en_out,
    output logic sqe_test_out,
    output logic scramble_dis_out,
    output logic irq_out
);

    // Flag and enable fields are fixed at one byte each
    generate
        if (EVENT_COUNT != 8)
        begin : g_bad_event_count
            $error("EVENT_COUNT must be 8");
        end
    endgenerate

    logic np_more_reg;
    logic np_msg_page_reg;
    logic np_ack2_reg;
    logic np_toggle_reg;
    logic [`NP_MSG_W-1:0] np_msg_reg;
    logic [15:0] partner_np_reg;
    logic [15:0] rxerr_cnt_reg;
    logic [7:0] irq_en_reg;
    logic [7:0] irq_flag_reg;
    logic [7:0] irq_flag_next;
    logic [7:0] evt;
    logic link_up_prev_reg;
    logic xover_dis_reg;
    logic force_link_reg;
    logic pwr_save_reg;
    logic irq_level_reg;
    logic jabber_en_reg;
    logic sqe_reg;
    logic scramble_dis_reg;
    logic irq_level_active;
    logic irq_pin_next;
    logic irq_pin_reg;
    phy_np_irq_pkg::reg_word_t rdata_next;
    phy_np_irq_pkg::reg_word_t local_np_word;
    phy_np_irq_pkg::reg_word_t ctrl_word;
    logic hit_next;
    logic wr_local;
    logic wr_irq;
    logic wr_ctrl;
    logic rd_irq;

    assign wr_local = reg_wr_in && (reg_addr_in == `ADDR_LOCAL_NP);
    assign wr_irq = reg_wr_in && (reg_addr_in == `ADDR_IRQ_CTRL);
    assign wr_ctrl = reg_wr_in && (reg_addr_in == `ADDR_PHY_CTRL);
    assign rd_irq = reg_rd_in && (reg_addr_in == `ADDR_IRQ_CTRL);

    // Local next page
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            np_more_reg <= 1'b0; // RULE_01
            np_msg_page_reg <= 1'b1; // RULE_02
            np_ack2_reg <= 1'b0; // RULE_03
            np_msg_reg <= `NP_MSG_RESET; // RULE_05
        end
        else if (clk_en_in && wr_local)
        begin
            np_more_reg <= reg_wdata_in[`NP_MORE_BIT]; // RULE_01
            np_msg_page_reg <= reg_wdata_in[`NP_MSG_PAGE_BIT]; // RULE_02
            np_ack2_reg <= reg_wdata_in[`NP_ACK2_BIT]; // RULE_03
            np_msg_reg <= reg_wdata_in[`NP_MSG_W-1:0]; // RULE_05
        end
    end

    // Toggle of the word last sent; writes do not touch it
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            np_toggle_reg <= 1'b0;
        end
        else if (clk_en_in && np_sent_in)
        begin
            np_toggle_reg <= np_sent_toggle_in; // RULE_04
        end
    end

    // Partner page capture; bit 11 is the inverse of our last sent toggle
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            partner_np_reg <= 16'h0000;
        end
        else if (clk_en_in && partner_np_valid_in)
        begin
            partner_np_reg <= partner_np_in; // RULE_06 RULE_08
            partner_np_reg[`NP_ACK_BIT] <= 1'b1; // RULE_06
            partner_np_reg[`NP_TOGGLE_BIT] <= ~np_toggle_reg; // RULE_07
        end
    end

    // Counter saturates so a long error burst cannot wrap to a small value
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            rxerr_cnt_reg <= 16'h0000;
        end
        else if (clk_en_in && rx_err_in && rx_pkt_active_in && rxerr_cnt_reg != 16'hffff)
        begin
            rxerr_cnt_reg <= rxerr_cnt_reg + 16'h0001; // RULE_09
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            irq_en_reg <= 8'h00;
        end
        else if (clk_en_in && wr_irq)
        begin
            irq_en_reg <= reg_wdata_in[15:`IRQ_EN_LSB]; // RULE_10
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            link_up_prev_reg <= 1'b0;
        end
        else if (clk_en_in)
        begin
            link_up_prev_reg <= link_up_in;
        end
    end

    always_comb
    begin
        evt = 8'h00;
        evt[`IRQ_FLAG_JABBER] = jabber_evt_in;
        evt[`IRQ_FLAG_RX_ERR] = rx_err_in && rx_pkt_active_in;
        evt[`IRQ_FLAG_PAGE_RX] = page_rx_evt_in;
        evt[`IRQ_FLAG_PAR_DET_FAULT] = par_det_fault_evt_in;
        evt[`IRQ_FLAG_PARTNER_ACK] = partner_ack_evt_in;
        evt[`IRQ_FLAG_LINK_DOWN] = link_up_prev_reg && !link_up_in; // RULE_12
        evt[`IRQ_FLAG_REMOTE_FAULT] = remote_fault_evt_in;
        evt[`IRQ_FLAG_LINK_UP] = !link_up_prev_reg && link_up_in; // RULE_12
    end

    // Event in the read cycle survives the clear so it is not lost
    generate
        for (genvar i = 0; i < EVENT_COUNT; i++)
        begin : g_flag
            assign irq_flag_next[i] = evt[i] | (irq_flag_reg[i] & ~rd_irq); // RULE_11
        end
    endgenerate

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            irq_flag_reg <= 8'h00;
        end
        else if (clk_en_in)
        begin
            irq_flag_reg <= irq_flag_next; // RULE_11
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            xover_dis_reg <= 1'b0;
            force_link_reg <= 1'b0;
            pwr_save_reg <= `CTL_PWR_SAVE_RESET;
            jabber_en_reg <= `CTL_JABBER_EN_RESET;
            sqe_reg <= 1'b0;
            scramble_dis_reg <= 1'b0;
        end
        else if (clk_en_in && wr_ctrl)
        begin
            xover_dis_reg <= reg_wdata_in[`CTL_XOVER_DIS_BIT]; // RULE_13
            force_link_reg <= reg_wdata_in[`CTL_FORCE_LINK_BIT]; // RULE_15
            pwr_save_reg <= reg_wdata_in[`CTL_PWR_SAVE_BIT]; // RULE_16
            jabber_en_reg <= reg_wdata_in[`CTL_JABBER_EN_BIT]; // RULE_18
            sqe_reg <= reg_wdata_in[`CTL_SQE_BIT]; // RULE_22
            scramble_dis_reg <= reg_wdata_in[`CTL_SCRAMBLE_DIS_BIT]; // RULE_22
        end
    end

    // Pin polarity kept apart from the controls that go to the PHY
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            irq_level_reg <= 1'b0;
        end
        else if (clk_en_in && wr_ctrl)
        begin
            irq_level_reg <= reg_wdata_in[`CTL_IRQ_LEVEL_BIT]; // RULE_17
        end
    end

    always_comb
    begin
        local_np_word = 16'h0000;
        local_np_word[`NP_MORE_BIT] = np_more_reg;
        local_np_word[`NP_MSG_PAGE_BIT] = np_msg_page_reg;
        local_np_word[`NP_ACK2_BIT] = np_ack2_reg;
        local_np_word[`NP_TOGGLE_BIT] = np_toggle_reg; // RULE_04
        local_np_word[`NP_MSG_W-1:0] = np_msg_reg;
        ctrl_word = 16'h0000;
        ctrl_word[`CTL_XOVER_DIS_BIT] = xover_dis_reg;
        ctrl_word[`CTL_ENERGY_BIT] = energy_in; // RULE_14
        ctrl_word[`CTL_FORCE_LINK_BIT] = force_link_reg;
        ctrl_word[`CTL_PWR_SAVE_BIT] = pwr_save_reg;
        ctrl_word[`CTL_IRQ_LEVEL_BIT] = irq_level_reg;
        ctrl_word[`CTL_JABBER_EN_BIT] = jabber_en_reg;
        ctrl_word[`CTL_AN_DONE_BIT] = an_done_in; // RULE_19
        ctrl_word[`CTL_PAUSE_BIT] = pause_result_in; // RULE_20
        ctrl_word[`CTL_ISOLATE_BIT] = isolate_in; // RULE_21
        ctrl_word[`CTL_SQE_BIT] = sqe_reg;
        ctrl_word[`CTL_SCRAMBLE_DIS_BIT] = scramble_dis_reg;
    end

    // Unmapped addresses read zero and clear the hit flag
    always_comb
    begin
        rdata_next = 16'h0000;
        hit_next = 1'b1;
        unique case (reg_addr_in)
            `ADDR_LOCAL_NP: rdata_next = local_np_word;
            `ADDR_PARTNER_NP: rdata_next = partner_np_reg; // RULE_06
            `ADDR_RXERR_CNT: rdata_next = rxerr_cnt_reg; // RULE_09
            `ADDR_IRQ_CTRL: rdata_next = {irq_en_reg, irq_flag_reg}; // RULE_11
            `ADDR_PHY_CTRL: rdata_next = ctrl_word;
            default: hit_next = 1'b0;
        endcase
    end

    // Read data registered; flags shown are those before the read clears them
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            reg_rdata_out <= 16'h0000;
            reg_hit_out <= 1'b0;
        end
        else if (clk_en_in && reg_rd_in)
        begin
            reg_rdata_out <= rdata_next;
            reg_hit_out <= hit_next;
        end
    end

    // Pin level follows the polarity bit
    assign irq_level_active = |(irq_flag_reg & irq_en_reg); // RULE_23
    assign irq_pin_next = irq_level_reg ? irq_level_active : ~irq_level_active; // RULE_17

    // Pin driven from a flop so it cannot glitch while flags and enables settle
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            irq_pin_reg <= 1'b1;
        end
        else if (clk_en_in)
        begin
            irq_pin_reg <= irq_pin_next; // RULE_23
        end
    end

    assign irq_out = irq_pin_reg;

    assign local_np_out = local_np_word;
    assign xover_dis_out = xover_dis_reg; // RULE_13
    assign force_link_out = force_link_reg; // RULE_15
    assign pwr_save_out = pwr_save_reg; // RULE_16
    assign jabber_en_out = jabber_en_reg; // RULE_18
    assign sqe_test_out = sqe_reg; // RULE_22
    assign scramble_dis_out = scramble_dis_reg; // RULE_22

endmodule : phy_nextpage_irq_ctrl_regs
`default_nettype wire

/* testbench/mgmt_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mgmt_master_model (
    input wire logic clk_sys_in,
    input wire logic [15:0] reg_rdata_in,
    output logic reg_rd_out,
    output logic reg_wr_out,
    output logic [4:0] reg_addr_out,
    output logic [15:0] reg_wdata_out
);
    initial
    begin
        reg_rd_out = 1'b0;
        reg_wr_out = 1'b0;
        reg_addr_out = 5'h00;
        reg_wdata_out = 16'h0000;
    end
    // Idle address and data are inverted so a stale value never passes as live
    task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
        output logic [15:0] q);
        @(posedge clk_sys_in);
        reg_rd_out <= ~w;
        reg_wr_out <= w;
        reg_addr_out <= a;
        reg_wdata_out <= d;
        @(posedge clk_sys_in);
        reg_rd_out <= 1'b0;
        reg_wr_out <= 1'b0;
        reg_addr_out <= ~a;
        reg_wdata_out <= ~d;
        @(posedge clk_sys_in);
        #1 q = reg_rdata_in;
    endtask : xfer
endmodule : mgmt_master_model
`default_nettype wire

/* testbench/phy_regs_props.sv */
`timescale 1ns/1ps
`default_nettype none
module phy_regs_props (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic reg_rd_in,
    input wire logic reg_wr_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic reg_hit_out,
    input wire logic np_sent_in,
    input wire logic np_sent_toggle_in,
    input wire logic energy_in,
    input wire logic an_done_in,
    input wire logic isolate_in,
    input wire logic [15:0] local_np_out,
    input wire logic xover_dis_out,
    input wire logic pwr_save_out,
    input wire logic sqe_test_out,
    input wire logic scramble_dis_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    logic rd_go;
    logic wr_go;
    logic mapped;
    assign rd_go = reg_rd_in && clk_en_in;
    assign wr_go = reg_wr_in && clk_en_in;
    assign mapped = reg_addr_in inside {5'h07, 5'h08, 5'h15, 5'h1b, 5'h1f};
    AST_RESET_VALUES: assert property ($rose(rst_n_in) |->
        local_np_out == 16'h2001 && pwr_save_out && !xover_dis_out) else $error("reset value");
    AST_NP_WRITE: assert property (wr_go && reg_addr_in == 5'h07 |=>
        (local_np_out & 16'hf7ff) == ($past(reg_wdata_in) & 16'hb7ff)) else $error("np write");
    AST_NP_TOGGLE: assert property (np_sent_in && clk_en_in |=>
        local_np_out[11] == $past(np_sent_toggle_in)) else $error("np toggle");
    AST_NP_HOLD: assert property (
        !(wr_go && reg_addr_in == 5'h07) && !(np_sent_in && clk_en_in)
        |=> $stable(local_np_out)) else $error("np changed");
    AST_CTL_WRITE: assert property (wr_go && reg_addr_in == 5'h1f |=>
        xover_dis_out == $past(reg_wdata_in[13]) && pwr_save_out == $past(reg_wdata_in[10])
        && {sqe_test_out, scramble_dis_out} == $past(reg_wdata_in[1:0])) else $error("ctl write");
    AST_CTL_STATUS: assert property (rd_go && reg_addr_in == 5'h1f |=>
        {reg_rdata_out[12], reg_rdata_out[7], reg_rdata_out[5]}
        == {$past(energy_in), $past(an_done_in), $past(isolate_in)}) else $error("status");
    AST_UNMAPPED: assert property (rd_go && !mapped |=> reg_rdata_out == 16'h0000 && !reg_hit_out)
        else $error("unmapped read");
    AST_HIT: assert property (rd_go && mapped |=> reg_hit_out) else $error("hit missing");
    AST_RDATA_STANDS: assert property (!rd_go |=> $stable(reg_rdata_out) && $stable(reg_hit_out))
        else $error("rdata moved");
    cover property (wr_go && reg_addr_in == 5'h07);
    cover property (rd_go && reg_addr_in == 5'h1b);
    cover property (rd_go && !mapped);
    cover property (!clk_en_in && reg_wr_in);
endmodule : phy_regs_props
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b1;
    logic [6:0] pl = 7'h00;
    logic tog = 1'b0;
    logic [15:0] pnp = 16'h0000;
    logic [3:0] st = 4'h0;
    logic rx_err = 1'b0;
    logic rx_act = 1'b0;
    logic link = 1'b0;
    logic rd, wr, hit, irq;
    logic [4:0] addr;
    logic [15:0] wdata, rdata, np_out;
    logic [5:0] ctl;
    int n_fail = 0;
    int total_checks = 0;
    localparam logic [4:0] RA [5] = '{5'h07, 5'h08, 5'h15, 5'h1b, 5'h1f};
    localparam logic [15:0] RV [5] = '{16'h2001, 16'h0000, 16'h0000, 16'h0000, 16'h0500};
    localparam logic [15:0] EVB [5] = '{16'h0080, 16'h0020, 16'h0010, 16'h0008, 16'h0002};
    always #5 clk = ~clk;
    phy_nextpage_irq_ctrl_regs phy_nextpage_irq_ctrl_regs_i (
        .clk_sys_in(clk), .rst_n_in(rst_n), .clk_en_in(en), .reg_rd_in(rd), .reg_wr_in(wr),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_hit_out(hit),
        .np_sent_in(pl[5]), .np_sent_toggle_in(tog), .partner_np_valid_in(pl[6]),
        .partner_np_in(pnp), .an_done_in(st[2]), .pause_result_in(st[1]), .rx_err_in(rx_err),
        .rx_pkt_active_in(rx_act), .energy_in(st[3]), .isolate_in(st[0]), .link_up_in(link),
        .jabber_evt_in(pl[0]), .page_rx_evt_in(pl[1]), .par_det_fault_evt_in(pl[2]),
        .partner_ack_evt_in(pl[3]), .remote_fault_evt_in(pl[4]), .local_np_out(np_out),
        .xover_dis_out(ctl[5]), .force_link_out(ctl[4]), .pwr_save_out(ctl[3]),
        .jabber_en_out(ctl[2]), .sqe_test_out(ctl[1]), .scramble_dis_out(ctl[0]), .irq_out(irq));
    mgmt_master_model mgmt_master_model_i (.clk_sys_in(clk), .reg_rdata_in(rdata),
        .reg_rd_out(rd), .reg_wr_out(wr), .reg_addr_out(addr), .reg_wdata_out(wdata));
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] q;
        mgmt_master_model_i.xfer(1'b0, a, 16'h0000, q);
        chk($sformatf("reg %h", a), exp, q);
    endtask : rd_chk
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] q;
        mgmt_master_model_i.xfer(1'b1, a, d, q);
    endtask : wr_reg
    task automatic pulse(input logic [6:0] p);
        @(posedge clk);
        pl <= p;
        @(posedge clk);
        pl <= 7'h00;
    endtask : pulse
    task automatic conclude();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (2000) @(posedge clk);
        n_fail++;
        $display("[ERR] watchdog expected done seen timeout");
        conclude();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++)
            rd_chk(RA[i], RV[i]);
        chk("irq", 16'h0001, {15'h0000, irq});
        chk("ctl", 16'h000c, {10'h000, ctl});
        rd_chk(5'h00, 16'h0000);
        chk("hit", 16'h0000, {15'h0000, hit});
        wr_reg(5'h07, 16'hffff);
        rd_chk(5'h07, 16'hb7ff);
        chk("np_out", 16'hb7ff, np_out);
        @(posedge clk);
        tog <= 1'b1;
        pnp <= 16'h1234;
        pulse(7'h20);
        rd_chk(5'h07, 16'hbfff);
        pulse(7'h40);
        rd_chk(5'h08, 16'h5234);
        @(posedge clk);
        tog <= 1'b0;
        pnp <= 16'h0000;
        pulse(7'h20);
        pulse(7'h40);
        wr_reg(5'h08, 16'hffff);
        wr_reg(5'h15, 16'hffff);
        rd_chk(5'h08, 16'h4800);
        @(posedge clk);
        rx_act <= 1'b1;
        rx_err <= 1'b1;
        repeat (3) @(posedge clk);
        rx_act <= 1'b0;
        repeat (2) @(posedge clk);
        rx_err <= 1'b0;
        rd_chk(5'h15, 16'h0003);
        wr_reg(5'h1b, 16'hffff);
        chk("irq", 16'h0000, {15'h0000, irq});
        rd_chk(5'h1b, 16'hff40);
        rd_chk(5'h1b, 16'hff00);
        chk("irq", 16'h0001, {15'h0000, irq});
        @(posedge clk);
        link <= 1'b1;
        rd_chk(5'h1b, 16'hff01);
        @(posedge clk);
        link <= 1'b0;
        rd_chk(5'h1b, 16'hff04);
        for (int i = 0; i < 5; i++)
        begin
            pulse(7'(1 << i));
            rd_chk(5'h1b, 16'hff00 | EVB[i]);
        end
        wr_reg(5'h1b, 16'h0100);
        pulse(7'h01);
        #1 chk("irq", 16'h0001, {15'h0000, irq});
        @(posedge clk);
        st <= 4'hd;
        wr_reg(5'h1f, 16'hffff);
        chk("irq", 16'h0000, {15'h0000, irq});
        chk("ctl", 16'h003f, {10'h000, ctl});
        rd_chk(5'h1f, 16'h3fa3);
        wr_reg(5'h1b, 16'h8000);
        chk("irq", 16'h0001, {15'h0000, irq});
        rd_chk(5'h1b, 16'h8080);
        chk("irq", 16'h0000, {15'h0000, irq});
        @(posedge clk);
        en <= 1'b0;
        wr_reg(5'h1f, 16'h0000);
        pulse(7'h01);
        @(posedge clk);
        en <= 1'b1;
        chk("ctl", 16'h003f, {10'h000, ctl});
        rd_chk(5'h1b, 16'h8000);
        @(posedge clk);
        st <= 4'h2;
        wr_reg(5'h1f, 16'h0000);
        rd_chk(5'h1f, 16'h0040);
        chk("ctl", 16'h0000, {10'h000, ctl});
        @(posedge clk);
        st <= 4'h0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++)
            rd_chk(RA[i], RV[i]);
        chk("irq", 16'h0001, {15'h0000, irq});
        conclude();
    end
endmodule : tb
bind phy_nextpage_irq_ctrl_regs phy_regs_props phy_regs_props_i (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_hit_out(reg_hit_out), .np_sent_in(np_sent_in), .np_sent_toggle_in(np_sent_toggle_in),
    .energy_in(energy_in), .an_done_in(an_done_in), .isolate_in(isolate_in),
    .local_np_out(local_np_out), .xover_dis_out(xover_dis_out), .pwr_save_out(pwr_save_out),
    .sqe_test_out(sqe_test_out), .scramble_dis_out(scramble_dis_out));
`default_nettype wire
